// ==== host_model.sv ====
// host controller model driving the serial pins
`timescale 1ns/1ps
module host_model (
   input  wire logic clk,
   output logic      shift_clock,
   output logic      latch_clock,
   output logic      clear_n,
   output logic      out_en_n,
   output logic      serial_in
);
   initial {shift_clock, latch_clock, clear_n, out_en_n, serial_in} = 5'h04;
   task automatic hold();
      repeat (4) @(negedge clk);
   endtask
   // msb first, data inverted once its hold has passed
   task automatic shift_bit(input logic b);
      serial_in <= b;
      hold();
      shift_clock <= 1'h1;
      hold();
      shift_clock <= 1'h0;
      serial_in <= ~b;
      hold();
   endtask
   task automatic latch();
      latch_clock <= 1'h1;
      hold();
      latch_clock <= 1'h0;
      hold();
   endtask
endmodule // host_model

// ==== latch_fifo.sv ====
// word buffer between the shift stages and the storage register
`timescale 1ns/1ps
module latch_fifo
   import shift_latch_pkg::*;
#(
   parameter int W     = DATA_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         flush,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wr;
      logic [AW-1:0]           rd;
      logic [CW-1:0]           cnt;
      logic                    full;
      logic                    empty;
   } fifo_state_t;

   fifo_state_t st_r;
   fifo_state_t st_nxt;
   logic        push;
   logic        pop;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction

   assign in_ready  = ~st_r.full;
   assign out_valid = ~st_r.empty;
   assign out_data  = st_r.mem[st_r.rd];
   assign push      = in_valid & ~st_r.full;
   assign pop       = out_ready & ~st_r.empty;

   always_comb begin
      st_nxt = st_r;
      if (flush) begin
         st_nxt.wr    = '0;
         st_nxt.rd    = '0;
         st_nxt.cnt   = '0;
      end else begin
         if (push) begin
            st_nxt.mem[st_r.wr] = in_data;
            st_nxt.wr           = ptr_inc(st_r.wr);
         end
         if (pop) begin
            st_nxt.rd = ptr_inc(st_r.rd);
         end
         if (push && !pop) begin
            st_nxt.cnt = CW'(st_r.cnt + 1'b1);
         end else if (pop && !push) begin
            st_nxt.cnt = CW'(st_r.cnt - 1'b1);
         end
      end
      st_nxt.full  = (st_nxt.cnt == CW'(DEPTH));
      st_nxt.empty = (st_nxt.cnt == '0);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r       <= '0;
         st_r.empty <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule // latch_fifo

// ==== shift_latch_driver.sv ====
// serial-in latched driver with eight open-drain sink outputs
`timescale 1ns/1ps

module shift_latch_driver
   import shift_latch_pkg::*;
#(
   parameter int W     = DATA_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic         SYS_CLK,
   input  wire logic         NRST,
   input  wire logic         SHIFT_CLOCK,
   input  wire logic         LATCH_CLOCK,
   input  wire logic         CLEAR_N,
   input  wire logic         OUT_ENABLE_N,
   input  wire logic         SERIAL_IN,
   input  wire logic         APPLY_READY,
   output logic              LATCH_READY,
   output logic              SERIAL_OUT,
   input  wire logic [W-1:0] SINK_OUT_I,
   output logic [W-1:0]      SINK_OUT_O,
   output logic [W-1:0]      SINK_OUT_OE
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      pin_in_t      sync1;
      pin_in_t      sync2;
      logic         prev_shift;
      logic         prev_latch;
      logic [W-1:0] shift;
      logic [W-1:0] storage;
      logic [W-1:0] buffer;
      logic         serial_out;
      logic         latch_ready;
   } drv_state_t;

   drv_state_t   st_r;
   drv_state_t   st_nxt;
   pin_in_t      pins;
   logic         latch_push;
   logic         fifo_in_ready;
   logic         fifo_out_valid;
   logic [W-1:0] fifo_out_data;
   logic         fifo_pop;
   logic         clearing;

   function automatic logic rise(input logic prev, input logic cur);
      rise = cur & ~prev;
   endfunction

   // ************************************************************
   // pin sampling
   // ************************************************************
   always_comb begin
      pins.shift_clock = SHIFT_CLOCK;
      pins.latch_clock = LATCH_CLOCK;
      pins.clear_n     = CLEAR_N;
      pins.out_en_n    = OUT_ENABLE_N;
      pins.serial_in   = SERIAL_IN;
   end

   assign clearing   = ~st_r.sync2.clear_n;
   assign latch_push = rise(st_r.prev_latch, st_r.sync2.latch_clock) & ~clearing;
   assign fifo_pop   = APPLY_READY & ~clearing;

   // ************************************************************
   // latched word buffer
   // ************************************************************
   latch_fifo #(
      .W     (W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk       (SYS_CLK),
      .rst_n     (NRST),
      .flush     (clearing),
      .in_valid  (latch_push),
      .in_data   (st_r.shift),
      .in_ready  (fifo_in_ready),
      .out_valid (fifo_out_valid),
      .out_data  (fifo_out_data),
      .out_ready (fifo_pop)
   );

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      st_nxt             = st_r;
      st_nxt.sync1       = pins;
      st_nxt.sync2       = st_r.sync1;
      st_nxt.prev_shift  = st_r.sync2.shift_clock;
      st_nxt.prev_latch  = st_r.sync2.latch_clock;
      st_nxt.latch_ready = fifo_in_ready;
      if (clearing) begin
         st_nxt.shift      = SHIFT_RST;
         st_nxt.storage    = STORAGE_RST;
         st_nxt.buffer     = BUFFER_RST;
         st_nxt.serial_out = SERIAL_OUT_RST;
      end else begin
         if (rise(st_r.prev_shift, st_r.sync2.shift_clock)) begin
            st_nxt.shift = {st_r.shift[W-2:0], st_r.sync2.serial_in};
         end
         if (rise(st_r.sync2.shift_clock, st_r.prev_shift)) begin
            st_nxt.serial_out = st_r.shift[W-1];
         end
         if (fifo_out_valid && fifo_pop) begin
            st_nxt.storage = fifo_out_data;
         end
         if (st_r.sync2.out_en_n) begin
            st_nxt.buffer = BUFFER_RST;
         end else begin
            st_nxt.buffer = st_r.storage;
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         st_r.sync1       <= PIN_RST;
         st_r.sync2       <= PIN_RST;
         st_r.prev_shift  <= 1'b0;
         st_r.prev_latch  <= 1'b0;
         st_r.shift       <= SHIFT_RST;
         st_r.storage     <= STORAGE_RST;
         st_r.buffer      <= BUFFER_RST;
         st_r.serial_out  <= SERIAL_OUT_RST;
         st_r.latch_ready <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign SERIAL_OUT  = st_r.serial_out;
   assign LATCH_READY = st_r.latch_ready;
   assign SINK_OUT_O  = '0;
   assign SINK_OUT_OE = st_r.buffer;

endmodule // shift_latch_driver

// ==== shift_latch_driver_asserts.sv ====
// port checker of the latched sink driver
`timescale 1ns/1ps
module shift_latch_driver_asserts #(parameter int W = 8) (
   input wire logic         SYS_CLK,
   input wire logic         NRST,
   input wire logic         SHIFT_CLOCK,
   input wire logic         CLEAR_N,
   input wire logic         OUT_ENABLE_N,
   input wire logic         APPLY_READY,
   input wire logic         LATCH_READY,
   input wire logic         SERIAL_OUT,
   input wire logic [W-1:0] SINK_OUT_O,
   input wire logic [W-1:0] SINK_OUT_OE
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);
   clear_zero_a: assert property ((!CLEAR_N)[*4] |-> !SINK_OUT_OE && !SERIAL_OUT)
      else $error("clear left outputs set");
   enable_off_a: assert property (OUT_ENABLE_N[*4] |-> !SINK_OUT_OE)
      else $error("sinks on while disabled");
   sink_low_a: assert property (!SINK_OUT_O)
      else $error("sink level not low");
   sink_cause_a: assert property (|SINK_OUT_OE |->
      $past(CLEAR_N, 3) && !$past(OUT_ENABLE_N, 3)) else $error("sink on without cause");
   serial_fall_a: assert property ($changed(SERIAL_OUT) |-> !$past(CLEAR_N, 3) ||
      $past(SHIFT_CLOCK, 4) && !$past(SHIFT_CLOCK, 3)) else $error("serial moved off fall");
   serial_hold_a: assert property ((SHIFT_CLOCK && CLEAR_N)[*4] |-> $stable(SERIAL_OUT))
      else $error("serial moved while clock high");
   fill_stall_a: assert property ($fell(LATCH_READY) |->
      !$past(APPLY_READY) || !$past(APPLY_READY, 2)) else $error("full without stall");
   ready_back_a: assert property (!LATCH_READY && APPLY_READY |-> ##[1:4] LATCH_READY)
      else $error("buffer did not drain");
   cover property ($fell(LATCH_READY));
   cover property ($rose(|SINK_OUT_OE));
   cover property ($rose(SERIAL_OUT));
endmodule // shift_latch_driver_asserts
bind shift_latch_driver shift_latch_driver_asserts #(.W(W)) u_chk (.SYS_CLK(SYS_CLK),
   .NRST(NRST), .SHIFT_CLOCK(SHIFT_CLOCK), .CLEAR_N(CLEAR_N), .OUT_ENABLE_N(OUT_ENABLE_N),
   .APPLY_READY(APPLY_READY), .LATCH_READY(LATCH_READY), .SERIAL_OUT(SERIAL_OUT),
   .SINK_OUT_O(SINK_OUT_O), .SINK_OUT_OE(SINK_OUT_OE));

// ==== shift_latch_driver_tb.sv ====
// testbench of the latched sink driver
`timescale 1ns/1ps
module shift_latch_driver_tb;
   import shift_latch_pkg::*;
   logic              SYS_CLK, NRST, APPLY_READY, LATCH_READY, SERIAL_OUT;
   logic              SHIFT_CLOCK, LATCH_CLOCK, CLEAR_N, OUT_ENABLE_N, SERIAL_IN;
   logic [DATA_W-1:0] SINK_OUT_O, SINK_OUT_OE, sh;
   logic [DATA_W-1:0] exp_q[$];
   logic [31:0]       rnd = 32'h0000_9214;
   int                error_cnt = 0;
   int                tests_run = 0;
   event              chk;
   initial begin
      SYS_CLK = 1'h0;
      forever #2 SYS_CLK = ~SYS_CLK;
   end
   host_model u_host (.clk(SYS_CLK), .shift_clock(SHIFT_CLOCK), .latch_clock(LATCH_CLOCK),
      .clear_n(CLEAR_N), .out_en_n(OUT_ENABLE_N), .serial_in(SERIAL_IN));
   shift_latch_driver u_dut (.SYS_CLK(SYS_CLK), .NRST(NRST), .SHIFT_CLOCK(SHIFT_CLOCK),
      .LATCH_CLOCK(LATCH_CLOCK), .CLEAR_N(CLEAR_N), .OUT_ENABLE_N(OUT_ENABLE_N),
      .SERIAL_IN(SERIAL_IN), .APPLY_READY(APPLY_READY), .LATCH_READY(LATCH_READY),
      .SERIAL_OUT(SERIAL_OUT), .SINK_OUT_I(~SINK_OUT_OE), .SINK_OUT_O(SINK_OUT_O),
      .SINK_OUT_OE(SINK_OUT_OE));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   task automatic cmp8(input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic cmp1(input logic e, input logic g);
      cmp8({7'h00, e}, {7'h00, g});
   endtask
   task automatic note(input logic [7:0] e);
      exp_q.push_back(e);
      u_host.hold();
      ->chk;
   endtask
   task automatic send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         u_host.shift_bit(b[i]);
         sh = {sh[6:0], b[i]};
         cmp1(sh[7], SERIAL_OUT);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial forever begin
      @chk;
      cmp8(exp_q.pop_front(), SINK_OUT_OE);
   end
   initial begin
      #40000;
      error_cnt++;
      stop_test();
   end
   initial begin
      NRST = 1'h0;
      APPLY_READY = 1'h1;
      sh = '0;
      repeat (3) @(negedge SYS_CLK);
      NRST <= 1'h1;
      note(8'h00);
      repeat (4) begin
         rnd = xs(rnd);
         send(rnd[7:0]);
         u_host.latch();
         note(rnd[7:0]);
      end
      $display("random bytes done");
      u_host.out_en_n <= 1'h1;
      note(8'h00);
      u_host.out_en_n <= 1'h0;
      note(rnd[7:0]);
      $display("enable done");
      send(~rnd[7:0]);
      note(rnd[7:0]);
      APPLY_READY <= 1'h0;
      repeat (16) u_host.latch();
      cmp1(1'h0, LATCH_READY);
      APPLY_READY <= 1'h1;
      note(~rnd[7:0]);
      $display("stall done");
      u_host.clear_n <= 1'h0;
      note(8'h00);
      cmp1(1'h0, SERIAL_OUT);
      u_host.clear_n <= 1'h1;
      u_host.latch();
      note(8'h00);
      $display("clear done");
      stop_test();
   end
endmodule // shift_latch_driver_tb

// ==== shift_latch_pkg.sv ====
// shared widths, reset values and carrier types of the latched sink driver
package shift_latch_pkg;

   // ************************************************************
   // widths and depths
   // ************************************************************
   localparam int          DATA_W       = 8;
   localparam int          FIFO_DEPTH   = 16;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [7:0]  SHIFT_RST    = 8'h00;
   localparam logic [7:0]  STORAGE_RST  = 8'h00;
   localparam logic [7:0]  BUFFER_RST   = 8'h00;
   localparam logic        SERIAL_OUT_RST = 1'b0;
   localparam logic        CLEAR_N_RST  = 1'b0;
   localparam logic        OUT_EN_N_RST = 1'b1;

   // ************************************************************
   // carrier types
   // ************************************************************
   typedef struct packed {
      logic shift_clock;
      logic latch_clock;
      logic clear_n;
      logic out_en_n;
      logic serial_in;
   } pin_in_t;

   localparam pin_in_t PIN_RST = '{shift_clock: 1'b0, latch_clock: 1'b0,
                                   clear_n: CLEAR_N_RST, out_en_n: OUT_EN_N_RST,
                                   serial_in: 1'b0};

endpackage
